/* File: acps_sequencer.sv */
// Conversion and power-up sequencer with serial readout for an 8-bit converter.
`timescale 1ns/1ps
module acps_sequencer #(
  parameter logic [15:0] PWR_INT_CYCLES = 16'(acps_pkg::PWR_INT_CYC)
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Converter control pins
  input wire logic conversion_start_n,
  input wire logic use_internal_ref,
  // Result of the two comparator flashes, coarse then fine
  input wire logic [3:0] flash_code,
  // Track-and-hold and power status
  output logic hold,
  output logic powered,
  // Serial link on its own clock
  input wire logic sclk,
  output logic receive_frame_sync,
  output logic serial_data,
  output logic serial_data_oe
);

  acps_pkg::acps_state_t state_reg;
  logic [2:0] start_sync_reg;
  logic start_level;
  logic start_fall;
  logic start_rise;
  logic pending_reg;
  logic [15:0] cnt_reg;
  logic [15:0] pwr_cnt_reg;
  logic [15:0] pwr_need;
  logic [7:0] result_reg;
  logic eoc_toggle_reg;
  logic conv_start;

  // Start pin is asynchronous; a change counts once stages two and three agree.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_sync_reg <= 3'h7;
    end else begin
      start_sync_reg <= {start_sync_reg[1:0], conversion_start_n};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_level <= 1'b1;
    end else if (start_sync_reg[1] == start_sync_reg[2]) begin
      start_level <= start_sync_reg[2];
    end
  end

  assign start_fall = start_level && (start_sync_reg[1] == start_sync_reg[2]) && !start_sync_reg[2];
  assign start_rise = !start_level && (start_sync_reg[1] == start_sync_reg[2]) && start_sync_reg[2];
  assign pwr_need = use_internal_ref ? PWR_INT_CYCLES : 16'(acps_pkg::PWR_EXT_CYC);

  // An early start edge is remembered and launched when power-up finishes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pending_reg <= 1'b0;
    end else if (state_reg == acps_pkg::ACPS_WAKING && start_fall) begin
      pending_reg <= 1'b1;
    end else if (state_reg != acps_pkg::ACPS_WAKING) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_cnt_reg <= 16'h0000;
    end else if (state_reg == acps_pkg::ACPS_WAKING) begin
      pwr_cnt_reg <= pwr_cnt_reg + 16'h0001;
    end else begin
      pwr_cnt_reg <= 16'h0000;
    end
  end

  assign conv_start = (state_reg == acps_pkg::ACPS_IDLE && start_fall) ||
                      (state_reg == acps_pkg::ACPS_WAKING && pwr_cnt_reg + 16'h0001 >= pwr_need
                       && (pending_reg || start_fall));

  // Main sequence; reset models supply application, so it lands powered down.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= acps_pkg::ACPS_OFF;
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      unique case (state_reg)
        acps_pkg::ACPS_OFF: begin
          if (start_rise) begin
            state_reg <= acps_pkg::ACPS_WAKING;
          end
        end
        acps_pkg::ACPS_WAKING: begin
          if (conv_start) begin
            state_reg <= acps_pkg::ACPS_HOLD;
            cnt_reg <= 16'h0001;
          end else if (pwr_cnt_reg + 16'h0001 >= pwr_need) begin
            state_reg <= acps_pkg::ACPS_IDLE;
          end
        end
        acps_pkg::ACPS_IDLE: begin
          if (conv_start) begin
            state_reg <= acps_pkg::ACPS_HOLD;
            cnt_reg <= 16'h0001;
          end
        end
        acps_pkg::ACPS_HOLD: begin
          if (cnt_reg == 16'(acps_pkg::HOLD_CYC)) begin
            state_reg <= acps_pkg::ACPS_COARSE;
          end
        end
        acps_pkg::ACPS_COARSE: begin
          if (cnt_reg == 16'(acps_pkg::COARSE_CYC)) begin
            state_reg <= acps_pkg::ACPS_FINE;
          end
        end
        acps_pkg::ACPS_FINE: begin
          if (cnt_reg == 16'(acps_pkg::CONV_CYC)) begin
            state_reg <= acps_pkg::ACPS_SAMPLE;
          end
        end
        acps_pkg::ACPS_SAMPLE: begin
          if (cnt_reg == 16'(acps_pkg::SAMPLE_CYC)) begin
            state_reg <= start_level ? acps_pkg::ACPS_IDLE : acps_pkg::ACPS_OFF;
          end
        end
      endcase
    end
  end

  // The code is straight binary; coarse digit lands high, fine digit low.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_reg <= 8'h00;
    end else if (state_reg == acps_pkg::ACPS_COARSE && cnt_reg == 16'(acps_pkg::COARSE_CYC)) begin
      result_reg[7:4] <= flash_code;
    end else if (state_reg == acps_pkg::ACPS_FINE && cnt_reg == 16'(acps_pkg::CONV_CYC)) begin
      result_reg[3:0] <= flash_code;
    end
  end

  // End of conversion is passed as a toggle; the result is stable until next start.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eoc_toggle_reg <= 1'b0;
    end else if (state_reg == acps_pkg::ACPS_FINE && cnt_reg == 16'(acps_pkg::CONV_CYC)) begin
      eoc_toggle_reg <= ~eoc_toggle_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold <= 1'b0;
      powered <= 1'b0;
    end else begin
      hold <= conv_start || (state_reg == acps_pkg::ACPS_HOLD &&
              cnt_reg != 16'(acps_pkg::HOLD_CYC));
      powered <= state_reg != acps_pkg::ACPS_OFF && state_reg != acps_pkg::ACPS_WAKING;
    end
  end

  // Start toggle for early frame-sync release, crossed into the serial domain.
  logic start_toggle_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_toggle_reg <= 1'b0;
    end else if (start_fall) begin
      start_toggle_reg <= ~start_toggle_reg;
    end
  end

  // Serial domain. The serial clock must run continuously, so these stages settle.
  logic [2:0] eoc_s_reg;
  logic [2:0] stt_s_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic frame_active_reg;
  logic eoc_event;
  logic stt_event;
  logic data_run_reg;

  always_ff @(posedge sclk) begin
    eoc_s_reg <= {eoc_s_reg[1:0], eoc_toggle_reg};
    stt_s_reg <= {stt_s_reg[1:0], start_toggle_reg};
  end

  assign eoc_event = eoc_s_reg[2] != eoc_s_reg[1];
  assign stt_event = stt_s_reg[2] != stt_s_reg[1];

  always_ff @(posedge sclk) begin
    if (eoc_event) begin
      receive_frame_sync <= 1'b0;
      frame_active_reg <= 1'b1;
      shift_reg <= {result_reg[6:0], 1'b0};
      serial_data <= result_reg[7];
      data_run_reg <= 1'b1;
      bit_cnt_reg <= 4'h1;
    end else if (frame_active_reg) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      serial_data <= shift_reg[7];
      shift_reg <= {shift_reg[6:0], 1'b0};
      if (bit_cnt_reg == acps_pkg::LAST_DATA_BIT || stt_event) begin
        frame_active_reg <= 1'b0;
        receive_frame_sync <= 1'b1;
        data_run_reg <= 1'b0;
      end
    end else begin
      receive_frame_sync <= 1'b1;
      frame_active_reg <= 1'b0;
      data_run_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      serial_data <= 1'b0;
      shift_reg <= shift_reg;
    end
  end

  // Driver enable turns on half a cycle before the first bit, so the receiver never
  // samples a released line; it is released on the falling edge that samples the eighth bit.
  always_ff @(negedge sclk) begin
    serial_data_oe <= eoc_event ||
                      (data_run_reg && bit_cnt_reg != acps_pkg::LAST_DATA_BIT);
  end

  // Counts rising edges seen with frame sync low, so an overlong frame shows at once.
  logic [3:0] fs_low_cnt_reg;
  always_ff @(posedge sclk) begin
    if (receive_frame_sync) begin
      fs_low_cnt_reg <= 4'h0;
    end else begin
      fs_low_cnt_reg <= fs_low_cnt_reg + 4'h1;
    end
  end

  // Cycle counts of the conversion, taken from the shared timing table.
  localparam int HOLD_DLY = acps_pkg::HOLD_CYC;
  localparam int COARSE_DLY = acps_pkg::COARSE_CYC;
  localparam int CONV_DLY = acps_pkg::CONV_CYC;

  // Steps of one conversion, counted from the first cycle in the hold state.
  sequence s_conv_launch;
    $rose(state_reg == acps_pkg::ACPS_HOLD);
  endsequence

  sequence s_hold_phase;
    hold [*6] ##1 !hold;
  endsequence

  sequence s_track_back;
    ##HOLD_DLY state_reg == acps_pkg::ACPS_COARSE && !hold;
  endsequence

  sequence s_coarse_done;
    ##COARSE_DLY state_reg == acps_pkg::ACPS_FINE;
  endsequence

  sequence s_fine_done;
    ##CONV_DLY state_reg == acps_pkg::ACPS_SAMPLE;
  endsequence

  a_hold_length: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(hold) |-> s_hold_phase) else $error("hold length wrong");
  a_track_return: assert property (@(posedge clk) disable iff (!rst_n)
    s_conv_launch |-> s_track_back) else $error("track not resumed");
  a_off_no_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == acps_pkg::ACPS_OFF |=> !hold && !powered)
    else $error("activity while powered down");
  a_off_at_start: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == acps_pkg::ACPS_OFF && !start_rise |=> state_reg == acps_pkg::ACPS_OFF)
    else $error("left power down without wake");
  a_wake_edge: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == acps_pkg::ACPS_OFF && start_rise |=> state_reg == acps_pkg::ACPS_WAKING)
    else $error("wake edge ignored");
  a_idle_start: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == acps_pkg::ACPS_IDLE && start_fall |=> state_reg == acps_pkg::ACPS_HOLD)
    else $error("start edge ignored");
  a_ext_powerup: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state_reg == acps_pkg::ACPS_WAKING) && !use_internal_ref |-> ##[1:51] powered)
    else $error("external power-up late");
  a_conv_time: assert property (@(posedge clk) disable iff (!rst_n)
    s_conv_launch |-> s_fine_done)
    else $error("conversion time wrong");
  a_coarse_time: assert property (@(posedge clk) disable iff (!rst_n)
    s_conv_launch |-> s_coarse_done)
    else $error("coarse step time wrong");
  a_coarse_nibble: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == acps_pkg::ACPS_COARSE && cnt_reg == 16'(acps_pkg::COARSE_CYC)
    |=> result_reg[7:4] == $past(flash_code)) else $error("coarse nibble lost");
  a_fine_nibble: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == acps_pkg::ACPS_FINE && cnt_reg == 16'(acps_pkg::CONV_CYC)
    |=> result_reg[3:0] == $past(flash_code)) else $error("fine nibble lost");
  a_deferred_start: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == acps_pkg::ACPS_WAKING && pending_reg && pwr_cnt_reg + 16'h0001 >= pwr_need
    |=> state_reg == acps_pkg::ACPS_HOLD && hold) else $error("deferred start lost");
  a_stay_powered: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == acps_pkg::ACPS_SAMPLE && cnt_reg == 16'(acps_pkg::SAMPLE_CYC) && start_level
    |=> state_reg == acps_pkg::ACPS_IDLE) else $error("powered down while high");
  a_auto_down: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == acps_pkg::ACPS_SAMPLE && cnt_reg == 16'(acps_pkg::SAMPLE_CYC) && !start_level
    |=> state_reg == acps_pkg::ACPS_OFF) else $error("no automatic power down");

  // The serial side has no reset; these only bind once the link clock has settled.
  a_frame_open: assert property (@(posedge sclk)
    eoc_event |=> !receive_frame_sync && serial_data == result_reg[7] && frame_active_reg)
    else $error("frame did not open");
  a_serial_word: assert property (@(posedge sclk)
    eoc_event |=> shift_reg[7:1] == result_reg[6:0])
    else $error("result not loaded");
  a_data_driven: assert property (@(posedge sclk)
    frame_active_reg && bit_cnt_reg == 4'h1 |-> serial_data_oe)
    else $error("data line not driven");
  a_data_release: assert property (@(posedge sclk)
    frame_active_reg && bit_cnt_reg == acps_pkg::LAST_DATA_BIT |-> !serial_data_oe)
    else $error("data line not released");
  a_frame_close: assert property (@(posedge sclk)
    frame_active_reg && bit_cnt_reg == acps_pkg::LAST_DATA_BIT
    |=> receive_frame_sync && !frame_active_reg) else $error("frame not closed");
  a_frame_length: assert property (@(posedge sclk)
    !receive_frame_sync |-> fs_low_cnt_reg + 4'h1 < acps_pkg::FRAME_END_BIT)
    else $error("frame too long");
  a_sync_idle: assert property (@(posedge sclk)
    !frame_active_reg && !eoc_event |=> receive_frame_sync)
    else $error("frame sync not idle");

endmodule // acps_sequencer

/* File: acps_pkg.sv */
// Package with constants and types for the conversion and power-up sequencer.
package acps_pkg;

  localparam int unsigned CLK_MHZ = 50;
  // Timing figures in nanoseconds as printed, and derived cycle counts.
  localparam int unsigned HOLD_NS = 120;
  localparam int unsigned COARSE_NS = 220;
  localparam int unsigned CONV_NS = 330;
  localparam int unsigned SAMPLE_NS = 530;
  localparam int unsigned PWR_EXT_NS = 1000;
  localparam int unsigned PWR_INT_NS = 25000;
  localparam int unsigned HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned COARSE_CYC = (COARSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PWR_EXT_CYC = (PWR_EXT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PWR_INT_CYC = (PWR_INT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned HALF_W = 4;
  localparam logic [3:0] FRAME_END_BIT = 4'h9;
  localparam logic [3:0] LAST_DATA_BIT = 4'h8;

  typedef enum logic [2:0] {
    ACPS_OFF,
    ACPS_WAKING,
    ACPS_IDLE,
    ACPS_HOLD,
    ACPS_COARSE,
    ACPS_FINE,
    ACPS_SAMPLE
  } acps_state_t;

  // Serial pin group driven toward the receiver.
  typedef struct packed {
    logic frame_sync_n;
    logic data;
    logic data_oe;
  } acps_serial_t;

endpackage

/* File: acps_receiver.sv */
// Serial receive port model that makes the link clock and collects frames.
`timescale 1ns/1ps
module acps_receiver (
  // Link clock made by the receiver
  output logic sclk,
  // Pins from the converter
  input wire logic receive_frame_sync,
  input wire logic serial_data,
  input wire logic serial_data_oe,
  // Collected results
  output logic [7:0] word,
  output logic [7:0] frames,
  output logic [7:0] bad_bits
);
  logic [7:0] shift_reg;
  logic [3:0] count;
  logic last;
  logic line;
  // A released line keeps no value, so the inverse of the last bit is seen.
  assign line = serial_data_oe ? serial_data : ~last;
  // The clock never stops, so frame sync can be launched from it at any time.
  initial begin
    sclk = 1'b0;
    word = 8'h00;
    frames = 8'h00;
    bad_bits = 8'h00;
    shift_reg = 8'h00;
    count = 4'h0;
    last = 1'b0;
    #7.3;
    forever #80 sclk = ~sclk;
  end
  always @(posedge sclk) begin
    if (serial_data_oe === 1'b1) last <= serial_data;
  end
  // Bits are taken on falling edges while frame sync is low.
  always @(negedge sclk) begin
    if (receive_frame_sync === 1'b0) begin
      if (serial_data_oe !== 1'b1) bad_bits <= bad_bits + 8'h01;
      shift_reg <= {shift_reg[6:0], line};
      count <= count + 4'h1;
      if (count == 4'h7) begin
        word <= {shift_reg[6:0], line};
        frames <= frames + 8'h01;
      end
    end else count <= 4'h0;
  end
endmodule // acps_receiver

/* File: acps_sequencer_test.sv */
// Self-checking testbench for the conversion and power-up sequencer.
`timescale 1ns/1ps
module acps_sequencer_test;
  localparam logic [15:0] INT_CYC = 16'h003c;
  localparam int EXT_CYC = acps_pkg::PWR_EXT_CYC;
  logic clk, rst_n, conversion_start_n, use_internal_ref, hold, powered;
  logic [3:0] flash_code;
  logic sclk, receive_frame_sync, serial_data, serial_data_oe;
  logic [7:0] word, frames, bad_bits;
  int n_errors = 0;
  int comparisons = 0;
  acps_sequencer #(.PWR_INT_CYCLES(INT_CYC)) i_acps_sequencer (.clk(clk), .rst_n(rst_n),
    .conversion_start_n(conversion_start_n), .use_internal_ref(use_internal_ref),
    .flash_code(flash_code), .hold(hold), .powered(powered), .sclk(sclk),
    .receive_frame_sync(receive_frame_sync), .serial_data(serial_data),
    .serial_data_oe(serial_data_oe));
  acps_receiver i_acps_receiver (.sclk(sclk), .receive_frame_sync(receive_frame_sync),
    .serial_data(serial_data), .serial_data_oe(serial_data_oe), .word(word),
    .frames(frames), .bad_bits(bad_bits));
  always #10 clk = ~clk;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_hold(output int t);
    t = 0;
    while (hold !== 1'b1 && t < 300) begin
      @(posedge clk);
      #1;
      t++;
    end
  endtask
  task automatic wake(input logic internal, input int need);
    int t;
    @(posedge clk);
    use_internal_ref <= internal;
    conversion_start_n <= 1'b1;
    t = 0;
    while (powered !== 1'b1 && t < need + 30) begin
      @(posedge clk);
      #1;
      t++;
    end
    check("wake_in_time", 16'(t >= need && t <= need + 6), 16'h1);
  endtask
  // One conversion with a given code; with power_down set the pin stays low to power down afterwards.
  task automatic convert(input logic [7:0] code, input logic power_down);
    int t;
    logic [7:0] f;
    repeat (20) @(posedge clk);
    f = frames;
    flash_code <= code[7:4];
    conversion_start_n <= 1'b0;
    wait_hold(t);
    t = 0;
    while (hold === 1'b1 && t < 20) begin
      @(posedge clk);
      #1;
      t++;
    end
    check("hold_cycles", 16'(t), 16'(acps_pkg::HOLD_CYC));
    repeat (7) @(posedge clk);
    flash_code <= code[3:0];
    if (!power_down) conversion_start_n <= 1'b1;
    t = 0;
    while (frames === f && t < 400) begin
      @(posedge clk);
      #1;
      t++;
    end
    check("frame_seen", 16'(frames !== f), 16'h1);
    check("result_word", {8'h00, word}, {8'h00, code});
    repeat (20) @(posedge clk);
    #1;
    check("frame_sync_back", {15'h0, receive_frame_sync}, 16'h1);
    check("data_released", {15'h0, serial_data_oe}, 16'h0);
  endtask
  initial begin
    logic [7:0] codes [4] = '{8'h00, 8'hff, 8'ha5, 8'h3c};
    int t;
    clk = 1'b0;
    rst_n = 1'b0;
    conversion_start_n = 1'b1;
    use_internal_ref = 1'b0;
    flash_code = 4'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (100) @(posedge clk);
    #1;
    check("powered_at_start", {15'h0, powered}, 16'h0);
    check("frame_sync_idle", {15'h0, receive_frame_sync}, 16'h1);
    @(posedge clk);
    conversion_start_n <= 1'b0;
    repeat (30) @(posedge clk);
    #1;
    check("no_hold_when_off", {15'h0, hold}, 16'h0);
    wake(1'b0, EXT_CYC);
    for (int i = 0; i < 4; i++) convert(codes[i], 1'b0);
    convert(8'h96, 1'b1);
    repeat (40) @(posedge clk);
    #1;
    check("auto_power_down", {15'h0, powered}, 16'h0);
    @(posedge clk);
    conversion_start_n <= 1'b1;
    repeat (10) @(posedge clk);
    conversion_start_n <= 1'b0;
    wait_hold(t);
    @(posedge clk);
    #1;
    check("start_deferred", 16'(t >= EXT_CYC - 10 && t <= EXT_CYC - 2 && powered === 1'b1), 16'h1);
    repeat (200) @(posedge clk);
    wake(1'b1, int'(INT_CYC));
    convert(8'h5a, 1'b0);
    check("serial_bit_errors", {8'h00, bad_bits}, 16'h0);
    final_report();
  end
  initial begin
    #400000;
    n_errors++;
    final_report();
  end
endmodule // acps_sequencer_test
